/* File: flash_program_write_guard.sv */
/*
  Flash program write guard: steers CPU external data moves to flash byte
  program or page erase, guarded by a two-key lock that relocks after each
  operation and locks until reset on misuse.
  Assumes a one-cycle special function register write strobe, a one-cycle
  external move write strobe, and supply monitor levels from another clock.

// Summary of operation
// - Control register bits 7:2 read zero, writes to them ignored.
// - Write enable set steers move writes to flash byte programming.
// - Erase and write enable both set: move write erases whole page.
// - Page erase ignores the data byte of the move write.
// - Erase enable clear: never erase, byte programming still possible.
// - Flash operations need first key then second key written.
// - After one completed operation the lock returns to locked.
// - Wrong key value in either position locks out until reset.
// - Flash operation while not unlocked is suppressed and locks out.
// - Key register read shows lock state in bits 1:0.
// - Supply monitor or its reset off: flash attempt causes error reset.
*/
`include "flash_guard_defs.svh"

module flash_program_write_guard
  import flash_guard_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic xmove_wr_i,
  input wire logic [15:0] xmove_addr_i,
  input wire logic [7:0] xmove_data_i,
  input wire logic supply_mon_en_i,
  input wire logic supply_rst_en_i,
  output logic [7:0] sfr_rdata_o,
  output logic cpu_stall_o,
  output logic flash_prog_o,
  output logic flash_erase_o,
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_data_o,
  output logic xram_wr_o,
  output logic [15:0] xram_addr_o,
  output logic [7:0] xram_data_o,
  output logic flash_err_rst_o
);

  localparam logic [7:0] prog_cyc = 8'(`PROG_CYC);
  localparam logic [7:0] erase_cyc = 8'(`ERASE_CYC);

  typedef struct packed {
    logic write_en;
    logic erase_en;
    lock_type lock;
    op_type op;
    logic [7:0] count;
    logic [2:0] mon_sync;
    logic [2:0] rst_sync;
    logic mon_ok;
    logic rst_ok;
    logic [7:0] rdata;
    logic stall;
    logic prog;
    logic erase;
    logic [15:0] faddr;
    logic [7:0] fdata;
    logic xwr;
    logic [15:0] xaddr;
    logic [7:0] xdata;
    logic err_rst;
  } state_type;

  state_type st;
  state_type next_st;

  function automatic logic [1:0] lock_code(input lock_type l);
    case (l)
      lock_idle: lock_code = `ST_LOCKED;
      lock_first: lock_code = `ST_FIRST;
      lock_open: lock_code = `ST_OPEN;
      default: lock_code = `ST_DEAD;
    endcase
  endfunction : lock_code

  always_comb
  begin
    next_st = st;
    next_st.prog = 1'b0;
    next_st.erase = 1'b0;
    next_st.xwr = 1'b0;
    next_st.err_rst = 1'b0;
    // Each level synchronised on its own; gating them first could glitch
    next_st.mon_sync = {st.mon_sync[1:0], supply_mon_en_i};
    next_st.rst_sync = {st.rst_sync[1:0], supply_rst_en_i};
    if (st.mon_sync[2] == st.mon_sync[1])
    begin
      next_st.mon_ok = st.mon_sync[2];
    end
    if (st.rst_sync[2] == st.rst_sync[1])
    begin
      next_st.rst_ok = st.rst_sync[2];
    end
    if (sfr_wr_i && sfr_addr_i == `PSC_ADDR)
    begin
      next_st.write_en = sfr_wdata_i[`PWE_BIT];
      next_st.erase_en = sfr_wdata_i[`PEE_BIT];
    end
    if (sfr_wr_i && sfr_addr_i == `FLK_ADDR)
    begin
      case (st.lock)
        lock_idle:
        begin
          next_st.lock = (sfr_wdata_i == `KEY_FIRST) ? lock_first : lock_dead;
        end
        lock_first:
        begin
          next_st.lock = (sfr_wdata_i == `KEY_SECOND) ? lock_open : lock_dead;
        end
        lock_open:
        begin
          next_st.lock = lock_dead;
        end
        default:
        begin
          next_st.lock = lock_dead;
        end
      endcase
    end
    case (st.op)
      op_idle:
      begin
        if (xmove_wr_i && !st.write_en)
        begin
          next_st.xwr = 1'b1;
          next_st.xaddr = xmove_addr_i;
          next_st.xdata = xmove_data_i;
        end
        else if (xmove_wr_i)
        begin
          if (!(st.mon_ok && st.rst_ok))
          begin
            next_st.err_rst = 1'b1;
          end
          else if (st.lock != lock_open)
          begin
            next_st.lock = lock_dead;
          end
          else
          begin
            next_st.stall = 1'b1;
            next_st.faddr = xmove_addr_i;
            if (st.erase_en)
            begin
              next_st.op = op_erase;
              next_st.erase = 1'b1;
              next_st.faddr = {xmove_addr_i[15:`PAGE_BITS], {`PAGE_BITS{1'b0}}};
              next_st.fdata = 8'h00;
              next_st.count = erase_cyc;
            end
            else
            begin
              next_st.op = op_prog;
              next_st.prog = 1'b1;
              next_st.fdata = xmove_data_i;
              next_st.count = prog_cyc;
            end
          end
        end
      end
      op_prog, op_erase:
      begin
        next_st.count = st.count - 8'h01;
        if (st.count == 8'h01)
        begin
          next_st.op = op_idle;
          next_st.stall = 1'b0;
          if (next_st.lock != lock_dead)
          begin
            next_st.lock = lock_idle;
          end
        end
      end
      default:
      begin
        next_st.op = op_idle;
      end
    endcase
    next_st.rdata = 8'h00;
    if (sfr_rd_i && sfr_addr_i == `PSC_ADDR)
    begin
      next_st.rdata = {6'b00_0000, next_st.erase_en, next_st.write_en};
    end
    else if (sfr_rd_i && sfr_addr_i == `FLK_ADDR)
    begin
      next_st.rdata = {6'b00_0000, lock_code(next_st.lock)};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sfr_rdata_o = st.rdata;
  assign cpu_stall_o = st.stall;
  assign flash_prog_o = st.prog;
  assign flash_erase_o = st.erase;
  assign flash_addr_o = st.faddr;
  assign flash_data_o = st.fdata;
  assign xram_wr_o = st.xwr;
  assign xram_addr_o = st.xaddr;
  assign xram_data_o = st.xdata;
  assign flash_err_rst_o = st.err_rst;

  chk_dead_sticks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st.lock == lock_dead |=> st.lock == lock_dead)
    else $error("lockout left");

  chk_bad_key: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sfr_wr_i && sfr_addr_i == `FLK_ADDR && st.lock == lock_idle && sfr_wdata_i != `KEY_FIRST
    |=> st.lock == lock_dead)
    else $error("bad first key accepted");

  chk_bad_second: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sfr_wr_i && sfr_addr_i == `FLK_ADDR && st.lock == lock_first && sfr_wdata_i != `KEY_SECOND
    |=> st.lock == lock_dead)
    else $error("bad second key accepted");

  chk_key_open: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sfr_wr_i && sfr_addr_i == `FLK_ADDR && st.lock == lock_first && sfr_wdata_i == `KEY_SECOND
    |=> st.lock == lock_open)
    else $error("key pair did not unlock");

  chk_rekey_open: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sfr_wr_i && sfr_addr_i == `FLK_ADDR && st.lock == lock_open |=> st.lock == lock_dead)
    else $error("key write while open not locked out");

  chk_locked_op: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st.op == op_idle && xmove_wr_i && st.write_en && st.mon_ok && st.rst_ok && st.lock != lock_open
    |=> !flash_prog_o && !flash_erase_o && st.lock == lock_dead)
    else $error("locked op ran");

  chk_erase_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    flash_erase_o |-> $past(st.erase_en) && $past(st.write_en))
    else $error("erase not enabled");

  chk_erase_page: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    flash_erase_o |-> flash_data_o == 8'h00 && flash_addr_o[`PAGE_BITS-1:0] == '0
    && flash_addr_o[15:`PAGE_BITS] == $past(xmove_addr_i[15:`PAGE_BITS]))
    else $error("erase page or data");

  chk_no_erase: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st.op == op_idle && xmove_wr_i && st.write_en && !st.erase_en |=> !flash_erase_o)
    else $error("erase without erase enable");

  chk_prog_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    flash_prog_o |-> flash_data_o == $past(xmove_data_i) && !$past(st.erase_en))
    else $error("prog data");

  chk_xram_pass: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    xmove_wr_i && !st.write_en && st.op == op_idle |=> xram_wr_o && !flash_prog_o && !flash_erase_o)
    else $error("xram");

  chk_relock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(cpu_stall_o) |-> st.lock != lock_open)
    else $error("no relock");

  chk_op_relock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st.op != op_idle && st.count == 8'h01 |=> st.lock == lock_idle || st.lock == lock_dead)
    else $error("lock left open after op");

  chk_err_rst: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    st.op == op_idle && xmove_wr_i && st.write_en && !(st.mon_ok && st.rst_ok)
    |=> flash_err_rst_o && !flash_prog_o && !flash_erase_o)
    else $error("no error reset");

  chk_stall_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    flash_prog_o |-> cpu_stall_o [*8] ##1 cpu_stall_o [*2] ##1 !cpu_stall_o)
    else $error("prog length");

  chk_erase_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    flash_erase_o |-> ##49 cpu_stall_o ##1 !cpu_stall_o)
    else $error("erase length");

  chk_stall_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    flash_prog_o || flash_erase_o |-> cpu_stall_o && !$past(cpu_stall_o))
    else $error("op started while stalled");

  chk_rd_code: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == `PSC_ADDR |=> sfr_rdata_o[7:2] == 6'b00_0000)
    else $error("reserved bits");

  chk_key_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == `FLK_ADDR && st.lock == lock_dead |=> sfr_rdata_o == 8'h03)
    else $error("lockout code");

  cov_prog: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) flash_prog_o);
  cov_erase: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) flash_erase_o);
  cov_dead: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) st.lock == lock_dead);
  cov_err: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) flash_err_rst_o);
  cov_xram: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) xram_wr_o);

endmodule : flash_program_write_guard

/* File: flash_guard_defs.svh */
/*
  Register offsets, field positions, reset values, key codes and timing counts
  for the flash program write guard.
  Assumes inclusion by its bare name from the design module, the CPU model and the bench.
*/
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH

`define PSC_ADDR 8'h8F
`define FLK_ADDR 8'hB7
`define PSC_RESET 2'b00
`define PWE_BIT 0
`define PEE_BIT 1
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
`define ST_LOCKED 2'b00
`define ST_FIRST 2'b01
`define ST_OPEN 2'b10
`define ST_DEAD 2'b11
`define PROG_NS 40
`define ERASE_NS 200
`define CLK_NS 4
`define PROG_CYC (((`PROG_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define ERASE_CYC (((`ERASE_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define PAGE_BITS 9

`endif

/* File: flash_guard_pkg.sv */
/*
  Types for the flash program write guard.
  Assumes flash_guard_defs.svh is visible on the include path.
*/
package flash_guard_pkg;
  typedef enum logic [1:0] {lock_idle, lock_first, lock_open, lock_dead} lock_type;
  typedef enum logic [1:0] {op_idle, op_prog, op_erase} op_type;
endpackage : flash_guard_pkg

/* File: cpu_model.sv */
/*
  CPU side model: register bus accesses and external data moves.
  Assumes the guard samples on the rising edge; drives change on the falling edge.
*/
`include "flash_guard_defs.svh"
module cpu_model
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic mv_o,
  output logic [15:0] mv_addr_o,
  output logic [7:0] mv_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    mv_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    mv_addr_o = 16'h0000;
    mv_data_o = 8'h00;
  end
  // Released data is inverted so a stale value never looks valid
  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : sfr_wr
  task sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    d = rdata_i;
    rd_o = 1'b0;
  endtask : sfr_rd
  task mv(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    mv_o = 1'b1;
    mv_addr_o = a;
    mv_data_o = d;
    @(negedge clk_i);
    mv_o = 1'b0;
    mv_addr_o = ~a;
    mv_data_o = ~d;
  endtask : mv
  task unlock;
    sfr_wr(`FLK_ADDR, `KEY_FIRST);
    sfr_wr(`FLK_ADDR, `KEY_SECOND);
  endtask : unlock
endmodule : cpu_model

/* File: tb.sv */
/*
  Self-checking bench for the flash program write guard.
  Assumes the cpu_model partner and the design's defines header.
*/
`include "flash_guard_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_n_i, mon_en, rst_en, sfr_wr, sfr_rd, mv_wr, stall, f_prog, f_erase, x_wr, err_rst;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, mv_data, f_data, x_data, v;
  logic [15:0] mv_addr, f_addr, x_addr;
  int n_fail = 0;
  int n_checks = 0;
  flash_program_write_guard flash_program_write_guard_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata),
    .xmove_wr_i(mv_wr), .xmove_addr_i(mv_addr), .xmove_data_i(mv_data), .supply_mon_en_i(mon_en),
    .supply_rst_en_i(rst_en), .sfr_rdata_o(sfr_rdata), .cpu_stall_o(stall), .flash_prog_o(f_prog),
    .flash_erase_o(f_erase), .flash_addr_o(f_addr), .flash_data_o(f_data), .xram_wr_o(x_wr),
    .xram_addr_o(x_addr), .xram_data_o(x_data), .flash_err_rst_o(err_rst));
  cpu_model cpu_model_inst (.clk_i(clk_sys_i), .rdata_i(sfr_rdata), .wr_o(sfr_wr), .rd_o(sfr_rd),
    .addr_o(sfr_addr), .wdata_o(sfr_wdata), .mv_o(mv_wr), .mv_addr_o(mv_addr), .mv_data_o(mv_data));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task do_reset;
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    // Supply levels need a few edges to pass the synchroniser
    repeat (8) @(negedge clk_sys_i);
  endtask : do_reset
  task lk(input logic [7:0] e);
    cpu_model_inst.sfr_rd(`FLK_ADDR, v);
    chk(16'(v), 16'(e));
  endtask : lk
  task mv_chk(input logic [15:0] a, input logic [7:0] d, input logic [4:0] p);
    cpu_model_inst.mv(a, d);
    chk(16'({stall, x_wr, f_prog, f_erase, err_rst}), 16'(p));
  endtask : mv_chk
  task t_regs;
    cpu_model_inst.sfr_rd(`PSC_ADDR, v);
    chk(16'(v), 16'h0000);
    lk(8'h00);
    cpu_model_inst.sfr_wr(`PSC_ADDR, 8'hFF);
    cpu_model_inst.sfr_rd(`PSC_ADDR, v);
    chk(16'(v), 16'h0003);
    cpu_model_inst.sfr_wr(`PSC_ADDR, 8'h02);
    mv_chk(16'h0043, 8'hC3, 5'b01000);
    cpu_model_inst.sfr_wr(`PSC_ADDR, 8'h00);
    mv_chk(16'h0042, 8'h3C, 5'b01000);
    chk(x_addr, 16'h0042);
    chk(16'(x_data), 16'h003C);
    lk(8'h00);
  endtask : t_regs
  task t_op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d, input logic [4:0] p,
            input logic [15:0] ea, input logic [7:0] ed, input int cyc);
    int n;
    cpu_model_inst.sfr_wr(`FLK_ADDR, `KEY_FIRST);
    lk(8'h01);
    cpu_model_inst.sfr_wr(`FLK_ADDR, `KEY_SECOND);
    lk(8'h02);
    cpu_model_inst.sfr_wr(`PSC_ADDR, ctl);
    mv_chk(a, d, p);
    chk(f_addr, ea);
    chk(16'(f_data), 16'(ed));
    n = 0;
    while (stall === 1'b1 && n < 100)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(16'(n), 16'(cyc));
    lk(8'h00);
    cpu_model_inst.sfr_wr(`PSC_ADDR, 8'h00);
  endtask : t_op
  task t_misuse;
    cpu_model_inst.sfr_wr(`PSC_ADDR, 8'h01);
    mv_chk(16'h0100, 8'h11, 5'b00000);
    lk(8'h03);
    do_reset();
    cpu_model_inst.sfr_wr(`FLK_ADDR, 8'h12);
    lk(8'h03);
    do_reset();
    cpu_model_inst.sfr_wr(`FLK_ADDR, `KEY_FIRST);
    cpu_model_inst.sfr_wr(`FLK_ADDR, 8'h00);
    lk(8'h03);
    do_reset();
    cpu_model_inst.unlock();
    cpu_model_inst.sfr_wr(`FLK_ADDR, `KEY_FIRST);
    lk(8'h03);
    do_reset();
  endtask : t_misuse
  task t_supply(input logic m, input logic r);
    mon_en = m;
    rst_en = r;
    repeat (8) @(negedge clk_sys_i);
    cpu_model_inst.unlock();
    cpu_model_inst.sfr_wr(`PSC_ADDR, 8'h01);
    mv_chk(16'h0200, 8'h22, 5'b00001);
    lk(8'h02);
    mon_en = 1'b1;
    rst_en = 1'b1;
    do_reset();
  endtask : t_supply
  initial
  begin
    rst_n_i = 1'b0;
    mon_en = 1'b1;
    rst_en = 1'b1;
    do_reset();
    t_regs();
    // Erase before programming the same location
    t_op(8'h03, 16'h1234, 8'h77, 5'b10010, 16'h1200, 8'h00, `ERASE_CYC);
    t_op(8'h01, 16'h1234, 8'h5A, 5'b10100, 16'h1234, 8'h5A, `PROG_CYC);
    t_misuse();
    t_supply(1'b0, 1'b1);
    t_supply(1'b1, 1'b0);
    test_done();
  end
  initial
  begin
    #20000;
    n_fail++;
    test_done();
  end
endmodule : tb
